// ### design/pcsi_top.sv
// transmit fifo and top level of the pcm codec serial interface
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// small synchronous fifo
// ------------------------------------------------------------
module pcsi_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  // clocking
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_depth_chk
    $error("fifo depth must be a power of two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_reg;
  logic [AW:0] rd_reg;
  logic push;
  logic pop;

  // full when pointers differ only in the wrap bit
  assign in_ready = !((wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]));
  assign out_valid = (wr_reg != rd_reg);
  assign out_data = mem[rd_reg[AW-1:0]];
  assign push = ce && in_valid && in_ready;
  assign pop = ce && out_valid && out_ready;

  // storage has no reset, pointers do
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_reg[AW-1:0]] <= in_data;
    end
  end

  // pointer update
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (pop)
      begin
        rd_reg <= rd_reg + 1'b1;
      end
    end
  end
endmodule

// Behaviour
// - strap high legacy, low multiplexed mode
// - multiplexed mode carries control bytes with voice
// - transmit pin driven only in its slot
// - legacy bits change on master clock rise
// - multiplexed output open drain, half rate
// - legacy receive samples on falling edges
// - multiplexed receive samples half rate, rising
// - receive rise one master period after transmit
// - three-level ring pin: first, second, pause
// - ring pin overrides processor ring control
// - a-law or mu-law selected by programming
// - maximum loudspeaker gain enables anticlipping
// - tone routed to earpiece or loudspeaker
// - sine or square tone, optionally to transmit
// - open-drain latch output pulls low while programmed bit is set
// - four clock rates, two barred in multiplexed
module pcsi_top #(
  parameter int unsigned DATA_W = 8,
  parameter int unsigned FIFO_DEPTH = 8
) (
  // clocking
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  // serial pins; inputs asynchronous to clk, outputs driven from clk
  input wire logic master_clk_pin,
  input wire logic frame_strobe,
  input wire logic interface_mode_strap,
  input wire logic receive_pcm_in,
  output logic transmit_pcm_out,
  output logic transmit_pcm_oe_n,
  // ring pin sensed as two comparator levels
  input wire logic ring_tone_select_pin_hi,
  input wire logic ring_tone_select_pin_lo,
  // processor-side control
  input wire pcsi_pkg::pcsi_cfg_s cfg,
  input wire pcsi_pkg::pcsi_ring_s cpu_ring,
  input wire logic ring_pin_enable,
  input wire logic [1:0] mclk_rate_sel,
  input wire logic [DATA_W-1:0] tx_ctl_byte,
  // transmit voice stream
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [DATA_W-1:0] tx_data,
  // receive bytes
  output logic rx_valid,
  output logic [DATA_W-1:0] rx_voice,
  output logic [DATA_W-1:0] rx_ctl,
  // status and analog-side controls
  output logic legacy_mode,
  output logic rate_error,
  output pcsi_pkg::pcsi_ring_s ring_ctl,
  output pcsi_pkg::pcsi_cfg_s cfg_q,
  output logic anticlip_en,
  output logic latch_out,
  output logic latch_oe_n
);
  if (DATA_W != pcsi_pkg::BYTE_W)
  begin : g_width_chk
    $error("only eight-bit pcm bytes are supported");
  end

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic mclk_s1, mclk_s2, mclk_s3;
  logic fs_s1, fs_s2, fs_s3;
  logic rxd_s1, rxd_s2;
  logic strap_s1, strap_s2;
  logic athi_s1, athi_s2;
  logic atlo_s1, atlo_s2;

  // two stages per pin; mclk and fs get a third for edges
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      {mclk_s1, mclk_s2, mclk_s3} <= 3'h0;
      {fs_s1, fs_s2, fs_s3} <= 3'h0;
      {rxd_s1, rxd_s2} <= 2'h3;
      {strap_s1, strap_s2} <= 2'h3;
      {athi_s1, athi_s2} <= 2'h0;
      {atlo_s1, atlo_s2} <= 2'h0;
    end
    else if (ce)
    begin
      {mclk_s1, mclk_s2, mclk_s3} <= {master_clk_pin, mclk_s1, mclk_s2};
      {fs_s1, fs_s2, fs_s3} <= {frame_strobe, fs_s1, fs_s2};
      {rxd_s1, rxd_s2} <= {receive_pcm_in, rxd_s1};
      {strap_s1, strap_s2} <= {interface_mode_strap, strap_s1};
      {athi_s1, athi_s2} <= {ring_tone_select_pin_hi, athi_s1};
      {atlo_s1, atlo_s2} <= {ring_tone_select_pin_lo, atlo_s1};
    end
  end

  logic mclk_rise;
  logic mclk_fall;
  logic fs_rise;
  assign mclk_rise = mclk_s2 && !mclk_s3;
  assign mclk_fall = !mclk_s2 && mclk_s3;
  assign fs_rise = fs_s2 && !fs_s3;

  // ------------------------------------------------------------
  // mode and configuration
  // ------------------------------------------------------------
  pcsi_pkg::pcsi_state_e state_reg;
  pcsi_pkg::pcsi_mode_e mode_reg;
  logic is_gci;
  assign is_gci = (mode_reg == pcsi_pkg::PCSI_MODE_GCI);
  assign legacy_mode = !is_gci;

  // strap is followed only between slots so a slot never changes format
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mode_reg <= pcsi_pkg::PCSI_MODE_LEGACY;
    end
    else if (ce && state_reg == pcsi_pkg::PCSI_ST_IDLE)
    begin
      mode_reg <= strap_s2 ? pcsi_pkg::PCSI_MODE_LEGACY : pcsi_pkg::PCSI_MODE_GCI;
    end
  end

  // registered copy of configuration and derived controls
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cfg_q <= '0;
      anticlip_en <= 1'b0;
      latch_out <= 1'b0;
      latch_oe_n <= 1'b1;
      rate_error <= 1'b0;
    end
    else if (ce)
    begin
      cfg_q <= cfg;
      anticlip_en <= cfg.ls_max_gain;
      latch_out <= 1'b0;
      latch_oe_n <= !cfg.latch_bit;
      rate_error <= is_gci && (mclk_rate_sel == pcsi_pkg::RATE_512K
                               || mclk_rate_sel == pcsi_pkg::RATE_2560K);
    end
  end

  // ------------------------------------------------------------
  // ringer control
  // ------------------------------------------------------------
  // pin levels: high first tone, low second tone, floating pause
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ring_ctl <= '0;
    end
    else if (ce)
    begin
      if (ring_pin_enable)
      begin
        ring_ctl.ring_on <= athi_s2 ^ atlo_s2;
        ring_ctl.ring_second <= atlo_s2 && !athi_s2;
      end
      else
      begin
        ring_ctl <= cpu_ring;
      end
    end
  end

  // ------------------------------------------------------------
  // transmit fifo
  // ------------------------------------------------------------
  logic q_valid;
  logic q_ready;
  logic [DATA_W-1:0] q_data;
  logic slot_start;

  // a byte leaves the queue only at a frame start, so the source stalls
  assign slot_start = ce && fs_rise && state_reg == pcsi_pkg::PCSI_ST_IDLE;
  assign q_ready = slot_start;

  pcsi_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_txq (
    .clk(clk),
    .arst_n(arst_n),
    .ce(ce),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .in_data(tx_data),
    .out_valid(q_valid),
    .out_ready(q_ready),
    .out_data(q_data)
  );

  // ------------------------------------------------------------
  // slot sequencer and shifters
  // ------------------------------------------------------------
  logic [pcsi_pkg::SLOT_W-1:0] tx_sh_reg;
  logic [pcsi_pkg::SLOT_W-1:0] rx_sh_reg;
  logic [4:0] out_cnt_reg;
  logic half_reg;
  logic drive_reg;
  logic tx_edge;
  logic rx_edge;
  logic [4:0] slot_bits;
  logic [DATA_W-1:0] idle_code;

  assign slot_bits = is_gci ? pcsi_pkg::GCI_BITS : pcsi_pkg::LEGACY_BITS;
  assign idle_code = cfg.mu_law ? pcsi_pkg::IDLE_MULAW : pcsi_pkg::IDLE_ALAW;

  // legacy: every rise; multiplexed: every second rise
  assign tx_edge = ce && state_reg == pcsi_pkg::PCSI_ST_SLOT && mclk_rise
                   && (!is_gci || !half_reg);
  // multiplexed receive rise is one master period after the transmit rise
  assign rx_edge = ce && drive_reg && (is_gci ? (mclk_rise && half_reg) : mclk_fall);

  // sequencer state
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg <= pcsi_pkg::PCSI_ST_IDLE;
      out_cnt_reg <= pcsi_pkg::CNT_ZERO;
      half_reg <= 1'b0;
      drive_reg <= 1'b0;
    end
    else if (ce)
    begin
      unique case (state_reg)
        pcsi_pkg::PCSI_ST_IDLE:
        begin
          if (fs_rise)
          begin
            state_reg <= pcsi_pkg::PCSI_ST_SLOT;
            out_cnt_reg <= pcsi_pkg::CNT_ZERO;
            half_reg <= 1'b0;
          end
        end
        pcsi_pkg::PCSI_ST_SLOT:
        begin
          if (is_gci && mclk_rise)
          begin
            half_reg <= !half_reg;
          end
          if (tx_edge)
          begin
            if (out_cnt_reg == slot_bits)
            begin
              drive_reg <= 1'b0;
              state_reg <= pcsi_pkg::PCSI_ST_IDLE;
            end
            else
            begin
              drive_reg <= 1'b1;
              out_cnt_reg <= out_cnt_reg + pcsi_pkg::CNT_ONE;
            end
          end
        end
      endcase
    end
  end

  // transmit shifter: voice byte first, control byte after it in multiplexed mode
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_sh_reg <= '0;
      transmit_pcm_out <= 1'b1;
    end
    else if (slot_start)
    begin
      tx_sh_reg <= {q_valid ? q_data : idle_code,
                    mode_reg == pcsi_pkg::PCSI_MODE_GCI ? tx_ctl_byte : pcsi_pkg::PAD_BYTE};
    end
    else if (tx_edge && out_cnt_reg != slot_bits)
    begin
      transmit_pcm_out <= tx_sh_reg[pcsi_pkg::SLOT_W-1];
      tx_sh_reg <= {tx_sh_reg[pcsi_pkg::SLOT_W-2:0], 1'b0};
    end
  end

  // open drain in multiplexed mode only pulls low; the pull-up makes ones
  assign transmit_pcm_oe_n = !(drive_reg && (!is_gci || !transmit_pcm_out));

  // receive shifter and byte hand-off
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rx_sh_reg <= '0;
      rx_voice <= '0;
      rx_ctl <= '0;
      rx_valid <= 1'b0;
    end
    else if (ce)
    begin
      rx_valid <= 1'b0;
      if (rx_edge)
      begin
        rx_sh_reg <= {rx_sh_reg[pcsi_pkg::SLOT_W-2:0], rxd_s2};
      end
      if (tx_edge && out_cnt_reg == slot_bits)
      begin
        rx_valid <= 1'b1;
        if (is_gci)
        begin
          rx_voice <= rx_sh_reg[pcsi_pkg::SLOT_W-1:DATA_W];
          rx_ctl <= rx_sh_reg[DATA_W-1:0];
        end
        else
        begin
          rx_voice <= rx_sh_reg[DATA_W-1:0];
        end
      end
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  idle_no_drive_a: assert property (state_reg == pcsi_pkg::PCSI_ST_IDLE |-> transmit_pcm_oe_n)
    else $error("transmit pin driven outside slot");
  legacy_rise_only_a: assert property (ce && !is_gci && $changed(transmit_pcm_out) |-> $past(mclk_rise))
    else $error("legacy data changed without master rise");
  gci_no_high_a: assert property (is_gci && !transmit_pcm_oe_n |-> !transmit_pcm_out)
    else $error("open drain drove a one");
  gci_half_rate_a: assert property (tx_edge && is_gci |-> !half_reg)
    else $error("multiplexed shift on wrong phase");
  legacy_fall_a: assert property (rx_edge && !is_gci |-> mclk_fall)
    else $error("legacy receive not on falling edge");
  gci_rx_phase_a: assert property (rx_edge && is_gci |-> mclk_rise && half_reg)
    else $error("multiplexed receive on wrong rise");
  mode_strap_a: assert property (ce && state_reg == pcsi_pkg::PCSI_ST_IDLE ##1 ce
                                 |-> legacy_mode == $past(strap_s2))
    else $error("mode does not follow strap");
  ring_pause_a: assert property (ce && ring_pin_enable && !athi_s2 && !atlo_s2 |=> !ring_ctl.ring_on)
    else $error("floating ring pin not a pause");
  anticlip_a: assert property (ce |=> anticlip_en == $past(cfg.ls_max_gain))
    else $error("anticlipping not tied to max gain");
  latch_a: assert property (ce |=> latch_oe_n == !$past(cfg.latch_bit))
    else $error("latch pin wrong");
  rate_a: assert property (ce && is_gci && mclk_rate_sel == pcsi_pkg::RATE_512K |=> rate_error)
    else $error("barred rate not flagged");
  byte_count_a: assert property (rx_valid |-> $past(out_cnt_reg) == slot_bits)
    else $error("slot closed with wrong bit count");

  legacy_slot_c: cover property (rx_valid && legacy_mode);
  gci_slot_c: cover property (rx_valid && !legacy_mode && rx_ctl != '0);
  fifo_full_c: cover property (!tx_ready && tx_valid);
  ring_pin_c: cover property (ring_pin_enable && ring_ctl.ring_second);
endmodule

`default_nettype wire

// ### design/pcsi_pkg.sv
// package: constants and carrier types for the pcm codec serial interface
package pcsi_pkg;

  // ------------------------------------------------------------
  // serial frame layout
  // ------------------------------------------------------------
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned SLOT_W = 16;
  localparam logic [4:0] LEGACY_BITS = 5'h08;
  localparam logic [4:0] GCI_BITS = 5'h10;
  localparam logic [4:0] CNT_ZERO = 5'h00;
  localparam logic [4:0] CNT_ONE = 5'h01;

  // ------------------------------------------------------------
  // idle codes sent when no voice byte is queued, and the legacy pad byte
  // ------------------------------------------------------------
  localparam logic [7:0] IDLE_ALAW = 8'hd5;
  localparam logic [7:0] IDLE_MULAW = 8'hff;
  localparam logic [7:0] PAD_BYTE = 8'h00;

  // ------------------------------------------------------------
  // master clock rate selection codes
  // ------------------------------------------------------------
  localparam logic [1:0] RATE_512K = 2'h0;
  localparam logic [1:0] RATE_1536K = 2'h1;
  localparam logic [1:0] RATE_2048K = 2'h2;
  localparam logic [1:0] RATE_2560K = 2'h3;

  // interface mode taken from the strap
  typedef enum logic
  {
    PCSI_MODE_GCI = 1'b0,
    PCSI_MODE_LEGACY = 1'b1
  } pcsi_mode_e;

  // slot sequencer
  typedef enum logic
  {
    PCSI_ST_IDLE = 1'b0,
    PCSI_ST_SLOT = 1'b1
  } pcsi_state_e;

  // processor-side audio configuration
  typedef struct packed
  {
    logic mu_law;
    logic ls_max_gain;
    logic tone_dual;
    logic tone_square;
    logic tone_to_ear;
    logic tone_to_ls;
    logic tone_to_tx;
    logic latch_bit;
  } pcsi_cfg_s;

  // ringer control from the processor or the pin
  typedef struct packed
  {
    logic ring_on;
    logic ring_second;
  } pcsi_ring_s;

endpackage

// ### tb/pcsi_far.sv
// far-side highway model: master clock, frame strobe, receive data
`timescale 1ns/1ps
`default_nettype none
module pcsi_far (
  // clocking
  input wire logic clk,
  // serial lines
  output logic mclk,
  output logic fs,
  output logic rx,
  input wire logic dx,
  // captured transmit bits
  output logic cap_stb,
  output logic [15:0] cap
);
  // quiet lines at time zero
  initial
  begin
    mclk = 1'b0;
    fs = 1'b0;
    rx = 1'b1;
    cap_stb = 1'b0;
    cap = 16'h0000;
  end

  // runs free since it also feeds the filters; close to the 2.048 mhz code
  always #244.14 mclk = ~mclk;

  // ----------------------------------------
  // one frame: 8 bits legacy, 16 multiplexed
  // ----------------------------------------
  task frame(input logic leg, input logic [15:0] bits);
    int i;
    cap = 16'h0000;
    @(negedge mclk);
    fs = 1'b1;
    for (i = 0; i < (leg ? 8 : 16); i++)
    begin
      @(posedge mclk);
      if (leg)
        rx = bits[15-i];
      @(negedge mclk);
      fs = 1'b0;
      if (!leg)
        rx = bits[15-i];
      cap = {cap[14:0], dx};
      // a multiplexed bit spans two periods: skip its sampling rise
      if (!leg)
        @(posedge mclk);
    end
    // wait one edge so the last sample never races the flip
    @(mclk);
    rx = ~rx;
    @(posedge clk);
    cap_stb <= 1'b1;
    @(posedge clk);
    cap_stb <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// self-checking bench for the pcm codec serial interface
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic ce = 1'b1;
  logic strap = 1'b1;
  logic ring_hi = 1'b0;
  logic ring_lo = 1'b0;
  logic ring_en = 1'b0;
  logic [1:0] rate = 2'h2;
  logic [7:0] ctl_byte = 8'h00;
  logic tx_valid = 1'b0;
  logic [7:0] tx_data = 8'h00;
  pcsi_pkg::pcsi_cfg_s cfg = '0;
  pcsi_pkg::pcsi_ring_s cpu_ring = '0;
  logic mclk, fs, rx, dx_out, dx_oe_n, tx_ready, rx_valid, legacy, rate_err;
  logic anticlip, latch_out, latch_oe_n, cap_stb, dx_wire;
  logic dx_last_reg = 1'b1;
  logic [7:0] rx_voice, rx_ctl;
  logic [15:0] cap;
  pcsi_pkg::pcsi_ring_s ring_ctl;
  pcsi_pkg::pcsi_cfg_s cfg_q;
  logic [15:0] rx_q[$];
  logic [15:0] cap_q[$];
  logic [15:0] lfsr_reg = 16'hf445;
  int errors = 0;
  int n_compared = 0;

  pcsi_top #(.DATA_W(8), .FIFO_DEPTH(8)) pcsi_top_i (
    .clk(clk), .arst_n(arst_n), .ce(ce), .master_clk_pin(mclk), .frame_strobe(fs),
    .interface_mode_strap(strap), .receive_pcm_in(rx), .transmit_pcm_out(dx_out),
    .transmit_pcm_oe_n(dx_oe_n), .ring_tone_select_pin_hi(ring_hi), .ring_tone_select_pin_lo(ring_lo),
    .cfg(cfg), .cpu_ring(cpu_ring), .ring_pin_enable(ring_en), .mclk_rate_sel(rate), .tx_ctl_byte(ctl_byte),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid), .rx_voice(rx_voice),
    .rx_ctl(rx_ctl), .legacy_mode(legacy), .rate_error(rate_err), .ring_ctl(ring_ctl), .cfg_q(cfg_q),
    .anticlip_en(anticlip), .latch_out(latch_out), .latch_oe_n(latch_oe_n)
  );
  pcsi_far pcsi_far_i (.clk(clk), .mclk(mclk), .fs(fs), .rx(rx), .dx(dx_wire), .cap_stb(cap_stb), .cap(cap));

  always #5 clk = ~clk;

  // pull-up when released in multiplexed mode; a floating legacy line shows no stale bit
  always @(posedge clk)
    if (dx_oe_n === 1'b0)
      dx_last_reg <= dx_out;
  assign dx_wire = (dx_oe_n === 1'b0) ? dx_out : (strap ? ~dx_last_reg : 1'b1);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function logic [7:0] rnd();
    lfsr_reg = {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
    return lfsr_reg[7:0];
  endfunction

  // expected bits on the line for one voice byte
  function logic [15:0] txe(input logic [7:0] v);
    return strap ? {8'h00, v} : {v, ctl_byte};
  endfunction

  task chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task chk_flag(input string what, input logic exp, input logic got);
    chk_word(what, {15'h0, exp}, {15'h0, got});
  endtask

  task wrap_up();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task settle();
    repeat (6) @(posedge clk);
    #1;
  endtask

  // valid held across pushes; stops where the fifo refuses
  task fill(input int n);
    int k;
    tx_valid = 1'b1;
    for (k = 0; k < n && tx_ready === 1'b1; k++)
    begin
      tx_data = rnd();
      cap_q.push_back(txe(tx_data));
      @(posedge clk);
      #1;
    end
    tx_valid = 1'b0;
  endtask

  task frame(input logic [7:0] v, input logic [7:0] c);
    rx_q.push_back({v, strap ? 8'h00 : c});
    pcsi_far_i.frame(strap, {v, c});
    settle();
    chk_flag("idle drive", 1'b1, dx_oe_n);
  endtask

  // scoreboard: each result against its oldest note
  always @(posedge clk)
  begin
    if (rx_valid === 1'b1)
      chk_word("rx bytes", rx_q.size() > 0 ? rx_q.pop_front() : 16'hxxxx, {rx_voice, rx_ctl});
    if (cap_stb === 1'b1)
      chk_word("tx bytes", cap_q.size() > 0 ? cap_q.pop_front() : 16'hxxxx, cap);
    if (legacy === 1'b0 && dx_oe_n === 1'b0)
      chk_flag("open drain", 1'b0, dx_out);
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    int i;
    logic [7:0] b;
    pcsi_pkg::pcsi_cfg_s prev;
    repeat (2) @(posedge clk);
    #1;
    chk_word("reset outs", 16'he800, {legacy, dx_oe_n, tx_ready, rx_valid, latch_oe_n, rate_err, ring_ctl, cfg_q});
    arst_n = 1'b1;
    settle();
    chk_flag("mode", 1'b1, legacy);
    // legacy: fill to refusal, drain one byte a frame
    fill(12);
    chk_word("fifo depth", 16'h0008, 16'(cap_q.size()));
    chk_flag("full", 1'b0, tx_ready);
    for (i = 0; i < 8; i++)
      frame(rnd(), 8'h00);
    // empty fifo sends the idle code of each law
    for (i = 0; i < 2; i++)
    begin
      cfg.mu_law = i[0];
      settle();
      cap_q.push_back(txe(i[0] ? pcsi_pkg::IDLE_MULAW : pcsi_pkg::IDLE_ALAW));
      frame(rnd(), 8'h00);
    end
    // multiplexed: voice and control both ways
    strap = 1'b0;
    ctl_byte = rnd();
    settle();
    chk_flag("mode", 1'b0, legacy);
    fill(1);
    frame(rnd(), rnd());
    cap_q.push_back(txe(pcsi_pkg::IDLE_MULAW));
    frame(rnd(), rnd());
    // every rate code in both modes
    for (i = 0; i < 8; i++)
    begin
      rate = i[1:0];
      strap = i[2];
      settle();
      chk_flag("rate", !i[2] && (i[1:0] == 2'h0 || i[1:0] == 2'h3), rate_err);
    end
    // ring pin levels with and without the override
    for (i = 0; i < 8; i++)
    begin
      ring_en = i[2];
      ring_hi = i[0] & ~i[1];
      ring_lo = i[1];
      b = rnd();
      cpu_ring = b[1:0];
      settle();
      chk_flag("ring on", i[2] ? ring_hi | ring_lo : cpu_ring.ring_on, ring_ctl.ring_on);
      if (!i[2] || ring_hi || ring_lo)
        chk_flag("ring second", i[2] ? ring_lo : cpu_ring.ring_second, ring_ctl.ring_second);
    end
    // random configuration, latch and anticlipping
    for (i = 0; i < 4; i++)
    begin
      // clock enable low must hold the old copy while cfg moves
      prev = cfg;
      b = rnd();
      ce = 1'b0;
      cfg = b;
      settle();
      chk_word("frozen cfg", {8'h00, prev}, {8'h00, cfg_q});
      ce = 1'b1;
      settle();
      chk_word("cfg copy", {8'h00, cfg}, {8'h00, cfg_q});
      chk_flag("anticlip", cfg.ls_max_gain, anticlip);
      chk_word("latch", {14'h0, 1'b0, ~cfg.latch_bit}, {14'h0, latch_out, latch_oe_n});
    end
    wrap_up();
  end

  // hang guard
  initial
  begin
    #400000;
    errors++;
    wrap_up();
  end
endmodule
`default_nettype wire
